// [hw/fault_status_pkg.sv]
`default_nettype none
package fault_status_pkg;

  // Register addresses as seen by the register read command
  localparam logic [4:0] ADDR_GENERAL = 5'h02;
  localparam logic [4:0] ADDR_POS     = 5'h03;
  localparam logic [4:0] ADDR_NEG     = 5'h04;
  localparam logic [4:0] ADDR_SERIAL  = 5'h05;
  localparam int         ADDR_W       = 5;

  // Register width and reset values
  localparam int         REG_W        = 8;
  localparam logic [7:0] GENERAL_RST  = 8'h00;
  localparam logic [7:0] POS_RST      = 8'h00;
  localparam logic [7:0] NEG_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;

  // General fault register field positions
  localparam int BIT_RESERVED   = 7;
  localparam int BIT_CMD_FAULT  = 6;
  localparam int BIT_SERIAL_SUM = 5;
  localparam int BIT_INPUT_SUM  = 4;
  localparam int BIT_WATCHDOG   = 3;
  localparam int BIT_REALIGN    = 2;
  localparam int BIT_OVERRUN    = 1;
  localparam int BIT_CHECK      = 0;

  // Threshold registers: channel flags in the low nibble, rest reserved
  localparam int MAX_CH         = 4;
  localparam int SERIAL_BITS_W  = 3;
  localparam int THRESH_SEL_W   = 3;

  // Index of each sticky flag inside the sticky flag bank
  localparam int STK_CMD        = 0;
  localparam int STK_WDT        = 1;
  localparam int STK_REALIGN    = 2;
  localparam int STK_OVERRUN    = 3;
  localparam int STK_CHECK      = 4;
  localparam int STK_N          = 5;

  // Command classes delivered by the command decoder
  typedef enum logic [2:0] {
    CMD_NULL,
    CMD_RREG,
    CMD_LOCK,
    CMD_UNLOCK,
    CMD_OTHER
  } cmd_kind_t;

endpackage
`default_nettype wire

// [hw/level_sync.sv]
`default_nettype none
module level_sync
  import fault_status_pkg::*;
#(
  parameter int W        = 1,
  parameter bit RST_VAL  = 1'b1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // Refused at elaboration: a zero-width chain has nothing to carry
  if (W < 1) begin : g_bad_w
    $error("level_sync needs W of at least 1");
  end

  // First stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q   <= {W{RST_VAL}};
      sync_out <= {W{RST_VAL}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// [hw/sticky_flags.sv]
`default_nettype none
module sticky_flags
  import fault_status_pkg::*;
#(
  parameter int N = STK_N
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Per-flag set and clear events
  input  wire logic [N-1:0] set_ev,
  input  wire logic [N-1:0] clr_ev,
  output logic      [N-1:0] flag_q
);

  // Refused at elaboration: an empty bank has no flags to hold
  if (N < 1) begin : g_bad_n
    $error("sticky_flags needs N of at least 1");
  end

  // Set beats clear so a fault arriving at a read is kept
  for (genvar i = 0; i < N; i++) begin : g_flag
    always_ff @(posedge clk) begin
      if (!resetn) begin
        flag_q[i] <= 1'b0;
      end else if (set_ev[i]) begin
        flag_q[i] <= 1'b1;
      end else if (clr_ev[i]) begin
        flag_q[i] <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [hw/adc_fault_status_regs.sv]
`default_nettype none
module adc_fault_status_regs
  import fault_status_pkg::*;
#(
  parameter int NUM_CH = MAX_CH
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // Command decoder events
  input  wire logic                    cmd_valid,
  input  wire cmd_kind_t               cmd_kind,
  input  wire logic                    cmd_recognized,
  input  wire logic                    cmd_check_fail,
  input  wire logic                    interface_locked,
  output logic                         cmd_execute_q,
  // Register read port
  input  wire logic                    rd_strobe,
  input  wire logic [ADDR_W-1:0]       rd_addr,
  output logic                         rd_valid_q,
  output logic [REG_W-1:0]             rd_data_q,
  // Null command status response
  output logic                         status_valid_q,
  output logic [REG_W-1:0]             status_q,
  // Fault sources
  input  wire logic [SERIAL_BITS_W-1:0] serial_fault_bits,
  input  wire logic [MAX_CH-1:0]       pos_over,
  input  wire logic [MAX_CH-1:0]       neg_over,
  input  wire logic [THRESH_SEL_W-1:0] comparator_threshold,
  output logic [THRESH_SEL_W-1:0]      comparator_threshold_q,
  input  wire logic                    watchdog_expired,
  input  wire logic                    sync_realign,
  input  wire logic                    sync_slave_mode,
  input  wire logic                    conversion_done,
  input  wire logic                    hamming_en,
  input  wire logic                    hamming_uncorrectable,
  input  wire logic                    crc_fail,
  // Serial link pin
  input  wire logic                    cs_n
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Only the two-channel and four-channel variants exist
  if (NUM_CH != 2 && NUM_CH != MAX_CH) begin : g_bad_ch
    $error("NUM_CH must be 2 or 4");
  end

  localparam logic [MAX_CH-1:0] CH_MASK = (NUM_CH == MAX_CH) ? 4'hf : 4'h3;

  logic                    frame_active;
  logic                    cs_n_sync;
  logic [STK_N-1:0]        stk_set;
  logic [STK_N-1:0]        stk_clr;
  logic [STK_N-1:0]        stk_q;
  logic [MAX_CH-1:0]       pos_q;
  logic [MAX_CH-1:0]       neg_q;
  logic                    serial_sum_q;
  logic                    input_sum_q;
  logic                    pos_seen_q;
  logic                    neg_seen_q;
  logic                    cmd_fault_ev;
  logic                    check_ev;
  logic                    null_accept;
  logic                    gen_xfer;
  logic                    serial_xfer;
  logic                    pos_rd;
  logic                    neg_rd;
  logic                    any_thresh;
  logic [REG_W-1:0]        general_val;
  logic [REG_W-1:0]        pos_val;
  logic [REG_W-1:0]        neg_val;

  // Chip select comes from a pin, so it is synchronised first
  level_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_cs_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (cs_n),
    .sync_out (cs_n_sync)
  );
  assign frame_active = !cs_n_sync;

  // Command classification
  assign check_ev     = (hamming_uncorrectable && hamming_en) || crc_fail;
  assign cmd_fault_ev = cmd_valid && !cmd_check_fail &&
                        (!cmd_recognized ||
                         (interface_locked && cmd_kind == CMD_OTHER));
  assign null_accept  = cmd_valid && !cmd_check_fail && cmd_recognized &&
                        cmd_kind == CMD_NULL;

  // Transfer events that may clear flags
  assign gen_xfer    = (rd_strobe && rd_addr == ADDR_GENERAL) || null_accept;
  assign serial_xfer = rd_strobe && rd_addr == ADDR_SERIAL;
  assign pos_rd      = rd_strobe && rd_addr == ADDR_POS;
  assign neg_rd      = rd_strobe && rd_addr == ADDR_NEG;

  // Sticky flag events; a set in the same cycle keeps the flag
  assign stk_set[STK_CMD]     = cmd_fault_ev;
  assign stk_clr[STK_CMD]     = gen_xfer;
  assign stk_set[STK_WDT]     = watchdog_expired;
  assign stk_clr[STK_WDT]     = gen_xfer;
  assign stk_set[STK_REALIGN] = sync_realign && sync_slave_mode;
  assign stk_clr[STK_REALIGN] = gen_xfer;
  assign stk_set[STK_OVERRUN] = conversion_done && frame_active;
  assign stk_clr[STK_OVERRUN] = gen_xfer;
  assign stk_set[STK_CHECK]   = check_ev;
  assign stk_clr[STK_CHECK]   = serial_xfer;

  sticky_flags #(
    .N (STK_N)
  ) u_flags (
    .clk    (clk),
    .resetn (resetn),
    .set_ev (stk_set),
    .clr_ev (stk_clr),
    .flag_q (stk_q)
  );

  // Threshold capture; missing channels are forced low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pos_q <= POS_RST[MAX_CH-1:0];
      neg_q <= NEG_RST[MAX_CH-1:0];
    end else begin
      pos_q <= pos_over & CH_MASK;
      neg_q <= neg_over & CH_MASK;
    end
  end

  // Threshold select forwarded to the comparators
  always_ff @(posedge clk) begin
    if (!resetn) begin
      comparator_threshold_q <= '0;
    end else begin
      comparator_threshold_q <= comparator_threshold;
    end
  end

  // Serial summary follows the serial bits and holds until read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      serial_sum_q <= 1'b0;
    end else if (|serial_fault_bits) begin
      serial_sum_q <= 1'b1;
    end else if (serial_xfer) begin
      serial_sum_q <= 1'b0;
    end
  end

  // Read tracking of both threshold registers; a fault while the summary is clear restarts it
  assign any_thresh = |(pos_q | neg_q);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pos_seen_q <= 1'b0;
      neg_seen_q <= 1'b0;
    end else if (any_thresh && !input_sum_q) begin
      pos_seen_q <= 1'b0;
      neg_seen_q <= 1'b0;
    end else begin
      pos_seen_q <= pos_seen_q || pos_rd;
      neg_seen_q <= neg_seen_q || neg_rd;
    end
  end

  // Input summary clears only once both reads happened and inputs are quiet
  always_ff @(posedge clk) begin
    if (!resetn) begin
      input_sum_q <= 1'b0;
    end else if (any_thresh) begin
      input_sum_q <= 1'b1;
    end else if (pos_seen_q && neg_seen_q) begin
      input_sum_q <= 1'b0;
    end
  end

  // Register images; reserved bits are constant zero
  always_comb begin
    general_val                 = GENERAL_RST;
    general_val[BIT_RESERVED]   = 1'b0;
    general_val[BIT_CMD_FAULT]  = stk_q[STK_CMD];
    general_val[BIT_SERIAL_SUM] = serial_sum_q;
    general_val[BIT_INPUT_SUM]  = input_sum_q;
    general_val[BIT_WATCHDOG]   = stk_q[STK_WDT];
    general_val[BIT_REALIGN]    = stk_q[STK_REALIGN];
    general_val[BIT_OVERRUN]    = stk_q[STK_OVERRUN];
    general_val[BIT_CHECK]      = stk_q[STK_CHECK];
    pos_val                     = {{(REG_W-MAX_CH){1'b0}}, pos_q};
    neg_val                     = {{(REG_W-MAX_CH){1'b0}}, neg_q};
  end

  // Read port; addresses not held here answer zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= UNMAPPED_VAL;
    end else begin
      rd_valid_q <= rd_strobe;
      if (rd_strobe) begin
        case (rd_addr)
          ADDR_GENERAL: rd_data_q <= general_val;
          ADDR_POS:     rd_data_q <= pos_val;
          ADDR_NEG:     rd_data_q <= neg_val;
          default:      rd_data_q <= UNMAPPED_VAL;
        endcase
      end
    end
  end

  // Null command response carries the general register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_valid_q <= 1'b0;
      status_q       <= GENERAL_RST;
    end else begin
      status_valid_q <= null_accept;
      if (null_accept) begin
        status_q <= general_val;
      end
    end
  end

  // Only clean, valid commands go on to execution
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd_execute_q <= 1'b0;
    end else begin
      cmd_execute_q <= cmd_valid && !cmd_fault_ev && !cmd_check_fail;
    end
  end

  // Checks
  cmd_fault_set_a: assert property (cmd_fault_ev |=> stk_q[STK_CMD])
    else $error("command fault not raised");
  locked_fault_a: assert property (
    cmd_valid && !cmd_check_fail && cmd_recognized && interface_locked &&
    cmd_kind == CMD_OTHER |=> stk_q[STK_CMD] && !cmd_execute_q)
    else $error("locked command not faulted");
  cmd_fault_clear_a: assert property (
    gen_xfer && !cmd_fault_ev && stk_q[STK_CMD] |=> !stk_q[STK_CMD])
    else $error("command fault not cleared on transfer");
  serial_sum_hold_a: assert property (
    serial_sum_q && !serial_xfer |=> serial_sum_q)
    else $error("serial summary dropped without read");
  input_sum_set_a: assert property (any_thresh |=> input_sum_q)
    else $error("input summary not set");
  input_sum_keep_a: assert property (
    input_sum_q && !(pos_seen_q && neg_seen_q) |=> input_sum_q)
    else $error("input summary cleared before both reads");
  watchdog_set_a: assert property (
    watchdog_expired |=> general_val[BIT_WATCHDOG])
    else $error("watchdog flag missing");
  realign_mode_a: assert property (
    !stk_q[STK_REALIGN] && !(sync_realign && sync_slave_mode)
    |=> !stk_q[STK_REALIGN])
    else $error("realign flag set outside slave sync");
  overrun_set_a: assert property (
    conversion_done && frame_active |=> stk_q[STK_OVERRUN])
    else $error("overrun not flagged");
  check_discard_a: assert property (
    cmd_valid && cmd_check_fail |=> !cmd_execute_q)
    else $error("checked-bad command executed");
  check_clear_a: assert property (
    serial_xfer && !check_ev && stk_q[STK_CHECK] |=> !stk_q[STK_CHECK])
    else $error("check flag not cleared on serial transfer");
  reserved_zero_a: assert property (
    rd_valid_q |-> rd_data_q[BIT_RESERVED] == 1'b0 &&
    ($past(rd_addr) == ADDR_GENERAL || rd_data_q[REG_W-1:MAX_CH] == '0))
    else $error("reserved bits read nonzero");
  pos_report_a: assert property (
    rd_strobe && rd_addr == ADDR_POS |=> rd_data_q[MAX_CH-1:0] == $past(pos_q))
    else $error("positive register mismatch");
  variant_zero_a: assert property (
    NUM_CH == 2 |-> pos_q[3:2] == 2'h0 && neg_q[3:2] == 2'h0)
    else $error("missing channels report faults");
  null_resp_a: assert property (
    null_accept |=> status_valid_q && status_q == $past(general_val))
    else $error("null response wrong");
  set_wins_a: assert property (
    (stk_set & stk_clr) != '0 |=>
    (stk_q & $past(stk_set & stk_clr)) == $past(stk_set & stk_clr))
    else $error("coinciding fault lost");

  null_seen_c: cover property (null_accept ##1 status_valid_q);
  input_clear_c: cover property (input_sum_q ##[1:20] !input_sum_q);
  locked_bad_c: cover property (cmd_fault_ev && interface_locked);
  overrun_c: cover property (conversion_done && frame_active);

endmodule
`default_nettype wire

// [testbench/host_model.sv]
`default_nettype none
module host_model
  import fault_status_pkg::*;
(
  // Clock
  input  wire logic             clk,
  // Register read port
  output logic                  rd_strobe,
  output logic [ADDR_W-1:0]     rd_addr,
  input  wire logic             rd_valid_q,
  input  wire logic [REG_W-1:0] rd_data_q,
  // Command port
  output logic                  cmd_valid,
  output cmd_kind_t             cmd_kind,
  output logic                  cmd_recognized,
  output logic                  cmd_check_fail,
  // Chip select pin
  output logic                  cs_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle host: no frame, no request
  initial begin
    rd_strobe      = 1'b0;
    rd_addr        = '0;
    cmd_valid      = 1'b0;
    cmd_kind       = CMD_NULL;
    cmd_recognized = 1'b0;
    cmd_check_fail = 1'b0;
    cs_n           = 1'b1;
  end

  // One read; address scrambled after release so stale values are never trusted
  task automatic read(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d,
                      output logic v);
    @(posedge clk) #1;
    rd_strobe = 1'b1;
    rd_addr   = a;
    @(posedge clk) #1;
    rd_strobe = 1'b0;
    rd_addr   = ~a;
    v = rd_valid_q;
    d = rd_data_q;
  endtask

  // One decoded command; qualifiers inverted once the pulse is over
  task automatic command(input cmd_kind_t k, input logic rec, input logic chk,
                         output logic ex, output logic sv);
    @(posedge clk) #1;
    cmd_valid      = 1'b1;
    cmd_kind       = k;
    cmd_recognized = rec;
    cmd_check_fail = chk;
    @(posedge clk) #1;
    cmd_valid      = 1'b0;
    cmd_recognized = ~rec;
    cmd_check_fail = ~chk;
    ex = u_exec_probe();
    sv = adc_fault_status_regs_tb.status_valid_q;
  endtask

  function automatic logic u_exec_probe();
    return adc_fault_status_regs_tb.cmd_execute_q;
  endfunction

  // Chip select moves just after an edge, never on one, so the sampling is clean
  task automatic set_cs(input logic level);
    @(posedge clk) #1;
    cs_n = level;
  endtask
endmodule
`default_nettype wire

// [testbench/adc_fault_status_regs_tb.sv]
`default_nettype none
module adc_fault_status_regs_tb
  import fault_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {int ev; logic [7:0] e1; logic [7:0] e2;} row_t;

  logic                     clk, resetn, cmd_valid, cmd_recognized, cmd_check_fail;
  logic                     interface_locked, cmd_execute_q, rd_strobe, rd_valid_q;
  logic                     status_valid_q, cs_n, watchdog_expired, sync_realign;
  logic                     sync_slave_mode, conversion_done, hamming_en;
  logic                     hamming_uncorrectable, crc_fail, v, ex, sv;
  cmd_kind_t                cmd_kind;
  logic [ADDR_W-1:0]        rd_addr;
  logic [REG_W-1:0]         rd_data_q, status_q, rd_data_2ch, d;
  logic [SERIAL_BITS_W-1:0] serial_fault_bits;
  logic [MAX_CH-1:0]        pos_over, neg_over;
  logic [THRESH_SEL_W-1:0]  comparator_threshold, comparator_threshold_q;
  int                       errors, n_compared, cycles;
  row_t                     rows[8];

  adc_fault_status_regs #(.NUM_CH(4)) u_adc_fault_status_regs (
    .clk, .resetn, .cmd_valid, .cmd_kind, .cmd_recognized, .cmd_check_fail,
    .interface_locked, .cmd_execute_q, .rd_strobe, .rd_addr, .rd_valid_q, .rd_data_q,
    .status_valid_q, .status_q, .serial_fault_bits, .pos_over, .neg_over,
    .comparator_threshold, .comparator_threshold_q, .watchdog_expired, .sync_realign,
    .sync_slave_mode, .conversion_done, .hamming_en, .hamming_uncorrectable, .crc_fail,
    .cs_n);

  // Two-channel variant shares every input; only its read data is watched
  adc_fault_status_regs #(.NUM_CH(2)) u_adc_fault_status_regs_2ch (
    .clk, .resetn, .cmd_valid, .cmd_kind, .cmd_recognized, .cmd_check_fail,
    .interface_locked, .cmd_execute_q(), .rd_strobe, .rd_addr, .rd_valid_q(),
    .rd_data_q(rd_data_2ch), .status_valid_q(), .status_q(), .serial_fault_bits,
    .pos_over, .neg_over, .comparator_threshold, .comparator_threshold_q(),
    .watchdog_expired, .sync_realign, .sync_slave_mode, .conversion_done, .hamming_en,
    .hamming_uncorrectable, .crc_fail, .cs_n);

  host_model u_host_model (
    .clk, .rd_strobe, .rd_addr, .rd_valid_q, .rd_data_q, .cmd_valid, .cmd_kind,
    .cmd_recognized, .cmd_check_fail, .cs_n);

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("unexpected at %0t: run timed out", $time);
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // Register read with its answer checked
  task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
    u_host_model.read(a, d, v);
    check1(v, 1'b1, "read valid");
    check8(d, exp, what);
  endtask

  task automatic pulse(ref logic s);
    @(posedge clk) #1;
    s = 1'b1;
    @(posedge clk) #1;
    s = 1'b0;
  endtask

  // Raise one kind of fault event
  task automatic fire(input int ev);
    case (ev)
      0: begin
        u_host_model.command(CMD_OTHER, 1'b0, 1'b0, ex, sv);
        check1(ex, 1'b0, "unrecognized executed");
      end
      1: begin
        interface_locked = 1'b1;
        u_host_model.command(CMD_RREG, 1'b1, 1'b0, ex, sv);
        check1(ex, 1'b1, "locked read refused");
        u_host_model.command(CMD_OTHER, 1'b1, 1'b0, ex, sv);
        check1(ex, 1'b0, "locked other executed");
        interface_locked = 1'b0;
      end
      2: pulse(watchdog_expired);
      3: begin
        sync_slave_mode = 1'b1;
        pulse(sync_realign);
      end
      4: begin
        u_host_model.set_cs(1'b0);
        repeat (4) @(posedge clk);
        pulse(conversion_done);
        u_host_model.set_cs(1'b1);
        repeat (3) @(posedge clk);
      end
      5: begin
        hamming_en = 1'b1;
        pulse(hamming_uncorrectable);
      end
      6: pulse(crc_fail);
      default: begin
        hamming_en = 1'b0;
        pulse(hamming_uncorrectable);
        sync_slave_mode = 1'b0;
        pulse(sync_realign);
      end
    endcase
  endtask

  initial begin
    resetn = 1'b0;
    {interface_locked, watchdog_expired, sync_realign, sync_slave_mode} = '0;
    {conversion_done, hamming_en, hamming_uncorrectable, crc_fail} = '0;
    serial_fault_bits = '0;
    pos_over = '0;
    neg_over = '0;
    comparator_threshold = '0;
    rows = '{'{0, 8'h40, 8'h00}, '{1, 8'h40, 8'h00}, '{2, 8'h08, 8'h00},
             '{3, 8'h04, 8'h00}, '{4, 8'h02, 8'h00}, '{5, 8'h01, 8'h01},
             '{6, 8'h01, 8'h01}, '{7, 8'h00, 8'h00}};
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    rd(5'h02, GENERAL_RST, "general reset");
    rd(5'h03, POS_RST, "pos reset");
    rd(5'h04, NEG_RST, "neg reset");
    rd(5'h1f, UNMAPPED_VAL, "unmapped");
    $display("test reset done");
    // Each event but the gated-off last one: seen, cleared by general transfer unless it waits for serial read
    foreach (rows[i]) begin
      fire(rows[i].ev);
      rd(5'h02, rows[i].e1, "flag set");
      rd(5'h02, rows[i].e2, "after transfer");
      rd(5'h05, UNMAPPED_VAL, "serial addr");
      rd(5'h02, 8'h00, "after serial read");
    end
    $display("test table done");
    // Null command carries the general image and clears it
    pulse(watchdog_expired);
    u_host_model.command(CMD_NULL, 1'b1, 1'b0, ex, sv);
    check1(sv, 1'b1, "null status valid");
    check8(status_q, 8'h08, "null status");
    rd(5'h02, 8'h00, "null cleared");
    u_host_model.command(CMD_NULL, 1'b1, 1'b1, ex, sv);
    check1(ex, 1'b0, "check failed executed");
    $display("test command done");
    // Fault arriving with the clearing read survives it
    fork
      u_host_model.read(5'h02, d, v);
      pulse(watchdog_expired);
    join
    rd(5'h02, 8'h08, "set beats clear");
    rd(5'h02, 8'h00, "cleared later");
    serial_fault_bits = 3'b010;
    repeat (2) @(posedge clk);
    rd(5'h02, 8'h20, "serial summary");
    serial_fault_bits = '0;
    rd(5'h02, 8'h20, "serial held");
    rd(5'h05, UNMAPPED_VAL, "serial addr");
    rd(5'h02, 8'h00, "serial cleared");
    $display("test persist done");
    // Threshold registers and the input summary
    comparator_threshold = 3'h5;
    pos_over = 4'b1010;
    neg_over = 4'b0101;
    repeat (2) @(posedge clk);
    #1;
    check8({5'h00, comparator_threshold_q}, 8'h05, "threshold copy");
    rd(5'h03, 8'h0a, "pos flags");
    check8(rd_data_2ch, 8'h02, "pos two channel");
    rd(5'h04, 8'h05, "neg flags");
    check8(rd_data_2ch, 8'h01, "neg two channel");
    rd(5'h02, 8'h10, "input summary");
    pos_over = '0;
    neg_over = '0;
    repeat (2) @(posedge clk);
    rd(5'h02, 8'h00, "summary after both");
    // Second episode: the two sides read one at a time after the inputs went quiet
    pos_over = 4'b0001;
    repeat (2) @(posedge clk);
    #1 pos_over = '0;
    rd(5'h03, 8'h00, "pos quiet");
    rd(5'h02, 8'h10, "summary after one");
    rd(5'h04, 8'h00, "neg quiet");
    repeat (2) @(posedge clk);
    rd(5'h02, 8'h00, "summary after both");
    $display("test threshold done");
    // Reset in mid-run drops every latched flag
    pulse(watchdog_expired);
    @(posedge clk) #1;
    resetn = 1'b0;
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    rd(5'h02, GENERAL_RST, "general after reset");
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
